/* File: design/normalize_instr_pipe_pkg.sv */
package normalize_instr_pipe_pkg;

  // register byte offsets
  localparam logic [7:0]  ACC_OFS       = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam logic [7:0]  CTRL_OFS      = 8'h08;
  localparam logic [7:0]  AR_BASE       = 8'h20;
  localparam logic [7:0]  AR_STRIDE     = 8'h04;

  // field positions
  localparam int          STAT_ARP_LSB  = 0;
  localparam int          STAT_TC_BIT   = 3;
  localparam int          STAT_BUSY_BIT = 4;
  localparam int          STAT_DONE_BIT = 5;
  localparam int          CTRL_RUN_BIT  = 0;

  // values after reset
  localparam logic [31:0] ACC_RST       = 32'h0000_0000;
  localparam logic [15:0] AR_RST        = 16'h0000;
  localparam logic [2:0]  ARP_RST       = 3'h0;
  localparam logic        TC_RST        = 1'b0;
  localparam logic        RUN_RST       = 1'b0;
  localparam logic [7:0]  CNT_RST       = 8'h00;
  localparam logic [3:0]  WAIT_RST      = 4'h0;

  // default step of the pointed register per shift; unit steps of the repeat and wait counters
  localparam logic [15:0] NORMALIZE_INSTR_INC      = 16'h0001;
  localparam logic [7:0]  RPT_ONE       = 8'h01;
  localparam logic [3:0]  WAIT_ONE      = 4'h1;

  typedef struct packed {
    logic        is_normalize_instr;
    logic        ar_mod_en;
    logic [2:0]  ar_sel;
    logic [15:0] ar_delta;
    logic        arp_wr_en;
    logic [2:0]  arp_val;
    logic [7:0]  rpt_n;
    logic        ext_fetch;
    logic [3:0]  wait_p;
  } instr_word_type;

  typedef struct packed {
    logic           valid;
    instr_word_type w;
  } pipe_slot_type;

endpackage : normalize_instr_pipe_pkg

/* File: design/normalize_instr_step.sv */
module normalize_instr_step
  import normalize_instr_pipe_pkg::*;
(
  input  wire logic [31:0] acc,
  output logic             shift,
  output logic             tc,
  output logic [31:0]      acc_next
);

  always_comb begin
    shift    = 1'b0;
    tc       = 1'b1;
    acc_next = acc;
    if (acc != 32'h0000_0000 && acc[31] == acc[30]) begin // RQ7
      shift    = 1'b1;
      tc       = 1'b0;
      acc_next = {acc[30:0], 1'b0};
    end
  end

endmodule : normalize_instr_step

/* File: design/normalize_instr_pipe_ctrl.sv */
// Notes on behaviour
// RQ1 - normalize updates its aux register in execute; others update in decode.
// RQ2 - follower edits of the same aux register land before normalize's edit.
// RQ3 - follower pointer changes take effect before normalize executes.
// RQ4 - software should leave aux registers alone for two words after normalize.
// RQ5 - one word; one cycle, plus fetch waits; n cycles under repeat.
// RQ6 - repeated normalize stops shifting once normalized, idles for the rest.
// RQ7 - zero sets flag; equal top bits clear flag and shift; else set.
// RQ8 - without a given modification, the pointed register increments per shift.
// RQ9 - extra fetch cycles equal the wait cycles of an external fetch.
module normalize_instr_pipe_ctrl
  import normalize_instr_pipe_pkg::*;
#(
  parameter int AR_COUNT = 8
) (
  input  wire logic           clk,
  input  wire logic           sys_rst,
  input  wire logic           ce,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  input  wire logic           instr_valid,
  input  wire instr_word_type instr_word,
  output logic                instr_ready,
  output logic                retire,
  output logic                test_control_flag
);

  generate
    if (AR_COUNT < 1 || AR_COUNT > 8) begin : g_bad
      $error("AR_COUNT must be 1 to 8");
    end
  endgenerate

  logic [31:0]   accumulator_reg_q, accumulator_reg_d;
  logic [15:0]   aux_register_q [AR_COUNT];
  logic [15:0]   aux_register_d [AR_COUNT];
  logic [2:0]    aux_reg_pointer_q, aux_reg_pointer_d;
  logic          tc_q, tc_d;
  logic          run_q, run_d;
  logic          done_q, done_d;
  logic [7:0]    rpt_cnt_q, rpt_cnt_d;
  logic [3:0]    fetch_cnt_q, fetch_cnt_d;
  pipe_slot_type dec_q, dec_d, opr_q, opr_d, exe_q, exe_d;
  logic          retire_q, retire_d;
  logic          act_q, act_d;
  logic          wr_q, wr_d;
  logic [7:0]    addr_q, addr_d;
  logic [31:0]   hrdata_q, hrdata_d;
  logic [31:0]   rd_mux;
  logic          step_shift, step_tc;
  logic [31:0]   step_acc;
  logic          stall, advance, fetch_ok, accept, bw;
  logic          normalize_instr_live, normalize_instr_ar_we, dec_ar_we;
  logic [15:0]   normalize_instr_delta;

  normalize_instr_step u_step (
    .acc      (accumulator_reg_q),
    .shift    (step_shift),
    .tc       (step_tc),
    .acc_next (step_acc)
  );

  // pipeline control
  always_comb begin
    stall      = exe_q.valid && exe_q.w.is_normalize_instr &&
                 (8'(rpt_cnt_q + RPT_ONE) < exe_q.w.rpt_n); // RQ5
    advance    = run_q && !stall;
    fetch_ok   = !instr_word.ext_fetch ||
                 fetch_cnt_q == instr_word.wait_p; // RQ9
    instr_ready = ce && advance && fetch_ok;
    accept     = instr_valid && instr_ready;
    normalize_instr_live  = run_q && exe_q.valid && exe_q.w.is_normalize_instr && !done_q; // RQ6
    normalize_instr_ar_we = normalize_instr_live && step_shift; // RQ1
    normalize_instr_delta = exe_q.w.ar_mod_en ? exe_q.w.ar_delta : NORMALIZE_INSTR_INC; // RQ8
    dec_ar_we  = accept && instr_word.ar_mod_en && !instr_word.is_normalize_instr; // RQ1
    bw         = act_q && wr_q;
  end

  always_comb begin
    accumulator_reg_d = accumulator_reg_q;
    aux_reg_pointer_d = aux_reg_pointer_q;
    tc_d        = tc_q;
    run_d       = run_q;
    done_d      = done_q;
    rpt_cnt_d   = rpt_cnt_q;
    fetch_cnt_d = fetch_cnt_q;
    dec_d       = dec_q;
    opr_d       = opr_q;
    exe_d       = exe_q;
    retire_d    = 1'b0;
    // bus writes, overridden by the pipeline
    if (bw && addr_q == ACC_OFS) begin
      accumulator_reg_d = hwdata;
    end
    if (bw && addr_q == STAT_OFS) begin
      aux_reg_pointer_d = hwdata[STAT_ARP_LSB +: 3];
      tc_d              = hwdata[STAT_TC_BIT];
    end
    if (bw && addr_q == CTRL_OFS) begin
      run_d = hwdata[CTRL_RUN_BIT];
    end
    if (normalize_instr_live) begin
      tc_d = step_tc; // RQ7
      if (step_shift) begin
        accumulator_reg_d = step_acc;
      end else begin
        done_d = 1'b1; // RQ6
      end
    end
    if (accept && instr_word.arp_wr_en) begin
      aux_reg_pointer_d = instr_word.arp_val; // RQ3
    end
    if (accept) begin
      fetch_cnt_d = WAIT_RST;
    end else if (run_q && instr_valid && !fetch_ok) begin
      fetch_cnt_d = 4'(fetch_cnt_q + WAIT_ONE); // RQ9
    end
    if (advance) begin
      dec_d     = '{valid: accept, w: instr_word};
      opr_d     = dec_q;
      exe_d     = opr_q;
      retire_d  = exe_q.valid;
      rpt_cnt_d = CNT_RST;
      done_d    = 1'b0;
    end else if (stall && run_q) begin
      rpt_cnt_d = 8'(rpt_cnt_q + RPT_ONE); // RQ5
    end
  end

  // one entry per aux register
  generate
    for (genvar i = 0; i < AR_COUNT; i++) begin : g_ar
      always_comb begin
        aux_register_d[i] = aux_register_q[i];
        if (bw && addr_q == 8'(AR_BASE + AR_STRIDE * i)) begin
          aux_register_d[i] = hwdata[15:0];
        end
        if (normalize_instr_ar_we && aux_reg_pointer_q == 3'(i)) begin
          aux_register_d[i] = 16'(aux_register_q[i] + normalize_instr_delta); // RQ2
        end
        if (dec_ar_we && instr_word.ar_sel == 3'(i)) begin
          aux_register_d[i] = 16'(aux_register_d[i] + instr_word.ar_delta);
        end
      end
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          aux_register_q[i] <= AR_RST;
        end else if (ce) begin
          aux_register_q[i] <= aux_register_d[i];
        end
      end
    end
  endgenerate

  // ahb-lite slave, zero wait states
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      ACC_OFS:  rd_mux = accumulator_reg_d;
      STAT_OFS: begin
        rd_mux[STAT_ARP_LSB +: 3] = aux_reg_pointer_d;
        rd_mux[STAT_TC_BIT]       = tc_d;
        rd_mux[STAT_BUSY_BIT]     = exe_d.valid;
        rd_mux[STAT_DONE_BIT]     = done_d;
      end
      CTRL_OFS: rd_mux[CTRL_RUN_BIT] = run_d;
      default:  rd_mux = 32'h0000_0000;
    endcase
    for (int k = 0; k < AR_COUNT; k++) begin
      if (haddr[7:0] == 8'(AR_BASE + AR_STRIDE * k)) begin
        rd_mux = {16'h0000, aux_register_d[k]};
      end
    end
    act_d    = hsel && htrans[1] && hready;
    wr_d     = hwrite;
    addr_d   = haddr[7:0];
    hrdata_d = (act_d && !hwrite) ? rd_mux : hrdata_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accumulator_reg_q <= ACC_RST;
      aux_reg_pointer_q <= ARP_RST;
      tc_q        <= TC_RST;
      run_q       <= RUN_RST;
      done_q      <= 1'b0;
      rpt_cnt_q   <= CNT_RST;
      fetch_cnt_q <= WAIT_RST;
      dec_q       <= '0;
      opr_q       <= '0;
      exe_q       <= '0;
      retire_q    <= 1'b0;
      act_q       <= 1'b0;
      wr_q        <= 1'b0;
      addr_q      <= 8'h00;
      hrdata_q    <= 32'h0000_0000;
    end else if (ce) begin
      accumulator_reg_q <= accumulator_reg_d;
      aux_reg_pointer_q <= aux_reg_pointer_d;
      tc_q        <= tc_d;
      run_q       <= run_d;
      done_q      <= done_d;
      rpt_cnt_q   <= rpt_cnt_d;
      fetch_cnt_q <= fetch_cnt_d;
      dec_q       <= dec_d;
      opr_q       <= opr_d;
      exe_q       <= exe_d;
      retire_q    <= retire_d;
      act_q       <= act_d;
      wr_q        <= wr_d;
      addr_q      <= addr_d;
      hrdata_q    <= hrdata_d;
    end
  end

  assign hreadyout         = ce;
  assign hresp             = 1'b0;
  assign hrdata            = hrdata_q;
  assign retire            = retire_q;
  assign test_control_flag = tc_q;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_dec_not_normalize_instr;
    dec_ar_we |-> !instr_word.is_normalize_instr;
  endproperty
  a_dec_not_normalize_instr: assert property (p_dec_not_normalize_instr) // RQ1
    else $error("normalize edited aux register in decode");

  property p_normalize_instr_order;
    ce && normalize_instr_ar_we && !dec_ar_we |=>
      aux_register_q[$past(aux_reg_pointer_q)] ==
      16'($past(aux_register_q[aux_reg_pointer_q]) + $past(normalize_instr_delta));
  endproperty
  a_normalize_instr_order: assert property (p_normalize_instr_order) // RQ2
    else $error("normalize edit not applied on current value");

  property p_ptr_early;
    ce && accept && instr_word.arp_wr_en |=>
      aux_reg_pointer_q == $past(instr_word.arp_val);
  endproperty
  a_ptr_early: assert property (p_ptr_early) // RQ3
    else $error("pointer change not taken at decode");

  property p_single;
    run_q && exe_q.valid && exe_q.w.is_normalize_instr && exe_q.w.rpt_n <= RPT_ONE
      |-> advance;
  endproperty
  a_single: assert property (p_single) // RQ5
    else $error("single normalize took more than one cycle");

  property p_hold;
    ce && stall && run_q |=>
      exe_q == $past(exe_q) && rpt_cnt_q == 8'($past(rpt_cnt_q) + RPT_ONE);
  endproperty
  a_hold: assert property (p_hold) // RQ5
    else $error("repeated normalize left execute early");

  property p_nop;
    ce && done_q && stall && run_q && !bw |=>
      accumulator_reg_q == $past(accumulator_reg_q) && !$past(normalize_instr_ar_we);
  endproperty
  a_nop: assert property (p_nop) // RQ6
    else $error("shift after normalization finished");

  property p_zero;
    ce && normalize_instr_live && accumulator_reg_q == 32'h0000_0000 |=> tc_q;
  endproperty
  a_zero: assert property (p_zero) // RQ7
    else $error("zero accumulator did not set flag");

  property p_shift;
    ce && normalize_instr_live && accumulator_reg_q != 32'h0000_0000 &&
      accumulator_reg_q[31] == accumulator_reg_q[30] |=>
      !tc_q && accumulator_reg_q == {$past(accumulator_reg_q[30:0]), 1'b0};
  endproperty
  a_shift: assert property (p_shift) // RQ7
    else $error("normalize shift wrong");

  property p_inc;
    ce && normalize_instr_ar_we && !exe_q.w.ar_mod_en && !dec_ar_we |=>
      aux_register_q[$past(aux_reg_pointer_q)] ==
      16'($past(aux_register_q[aux_reg_pointer_q]) + NORMALIZE_INSTR_INC);
  endproperty
  a_inc: assert property (p_inc) // RQ8
    else $error("default increment missing");

  property p_wait;
    accept && instr_word.ext_fetch |-> fetch_cnt_q == instr_word.wait_p;
  endproperty
  a_wait: assert property (p_wait) // RQ9
    else $error("external fetch wait count wrong");

endmodule : normalize_instr_pipe_ctrl

/* File: bench/tb_normalize_instr_pipe_ctrl.sv */
module tb_normalize_instr_pipe_ctrl
  import normalize_instr_pipe_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk, sys_rst, hsel, hwrite, instr_valid;
  logic [31:0]    haddr, hwdata, hrdata, rd;
  logic [1:0]     htrans;
  logic           hreadyout, hresp, instr_ready, retire, test_control_flag;
  instr_word_type instr_word;
  int             bad_count, n_checks, cyc, n_ret, n_ins, w, tot;
  logic [31:0]    ai [3] = '{32'h0000_0000, 32'h8000_0000, 32'hFFFF_F001};
  logic [31:0]    ao [3] = '{32'h0000_0000, 32'h8000_0000, 32'hFFFF_E002};
  logic           tf [3] = '{1'h1, 1'h1, 1'h0};

  normalize_instr_pipe_ctrl #(.AR_COUNT(8)) i_normalize_instr_pipe_ctrl (
    .clk(clk), .sys_rst(sys_rst), .ce(1'h1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .retire(retire),
    .test_control_flag(test_control_flag)
  );

  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cyc++;
    if (retire === 1'h1) n_ret++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hsel   <= 1'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : bus

  task issue(input instr_word_type iw);
    instr_valid <= 1'h1;
    instr_word  <= iw;
    w = 0;
    do begin
      @(posedge clk);
      w++;
    end while (instr_ready !== 1'h1);
    n_ins++;
  endtask : issue

  task idle(input int n);
    instr_valid <= 1'h0;
    repeat (n) @(posedge clk);
  endtask : idle

  function automatic instr_word_type mk(logic n, logic me, logic [2:0] s,
      logic [15:0] d, logic pe, logic [2:0] p, logic [7:0] r, logic x,
      logic [3:0] wp);
    mk = '{n, me, s, d, pe, p, r, x, wp};
  endfunction : mk

  function automatic logic [7:0] ara(input int i);
    ara = AR_BASE + AR_STRIDE * 8'(i);
  endfunction : ara

  initial begin
    sys_rst = 1'h1; hsel = 1'h0; haddr = 32'h0000_0000; htrans = 2'h0;
    hwrite = 1'h0; hwdata = 32'h0000_0000; instr_valid = 1'h0;
    instr_word = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    chk({31'h0000_0000, instr_ready}, 32'h0000_0000);
    bus(1'h0, ACC_OFS, 32'h0000_0000); chk(rd, ACC_RST);
    bus(1'h0, STAT_OFS, 32'h0000_0000); chk(rd, 32'h0000_0000);
    bus(1'h1, 8'h10, 32'hFFFF_FFFF);
    bus(1'h0, 8'h10, 32'h0000_0000); chk(rd, 32'h0000_0000);
    bus(1'h1, CTRL_OFS, 32'h0000_0001);
    // late update of normalize, early for others
    bus(1'h1, STAT_OFS, 32'h0000_000A);
    bus(1'h1, ara(2), 32'h0000_0010);
    bus(1'h1, ACC_OFS, 32'h2000_0000);
    issue(mk(1, 0, 0, 0, 0, 0, 1, 0, 0)); idle(0);
    bus(1'h0, ara(2), 32'h0); chk(rd, 32'h0000_0010);
    idle(6);
    bus(1'h0, ara(2), 32'h0); chk(rd, 32'h0000_0011);
    bus(1'h0, ACC_OFS, 32'h0); chk(rd, 32'h4000_0000);
    chk({31'h0000_0000, test_control_flag}, 32'h0000_0000);
    issue(mk(0, 1, 2, 16'h0003, 0, 0, 0, 0, 0)); idle(0);
    bus(1'h0, ara(2), 32'h0); chk(rd, 32'h0000_0014);
    // zero, differing and negative cases
    for (int k = 0; k < 3; k++) begin
      bus(1'h1, STAT_OFS, {28'h000_0000, ~tf[k], 3'h2});
      bus(1'h1, ara(2), 32'h0000_0000);
      bus(1'h1, ACC_OFS, ai[k]);
      issue(mk(1, 0, 0, 0, 0, 0, 1, 0, 0)); idle(8);
      bus(1'h0, ACC_OFS, 32'h0); chk(rd, ao[k]);
      bus(1'h0, ara(2), 32'h0); chk(rd, {31'h0, ~tf[k]});
      chk({31'h0, test_control_flag}, {31'h0, tf[k]});
    end
    // followers edit the register and move the pointer
    bus(1'h1, STAT_OFS, 32'h0000_0002);
    bus(1'h1, ara(2), 32'h0000_0100);
    bus(1'h1, ara(3), 32'h0000_0200);
    bus(1'h1, ACC_OFS, 32'h1000_0000);
    issue(mk(1, 1, 0, 16'h0004, 0, 0, 1, 0, 0));
    issue(mk(0, 1, 3, 16'h0010, 0, 0, 0, 0, 0));
    issue(mk(0, 0, 0, 0, 1, 3, 0, 0, 0)); idle(8);
    bus(1'h0, ara(3), 32'h0); chk(rd, 32'h0000_0214);
    bus(1'h0, ara(2), 32'h0); chk(rd, 32'h0000_0100);
    bus(1'h0, STAT_OFS, 32'h0); chk(rd & 32'h7, 32'h0000_0003);
    // repeated normalize with early normalization
    bus(1'h1, STAT_OFS, 32'h0000_0001);
    bus(1'h1, ara(1), 32'h0000_0000);
    bus(1'h1, ACC_OFS, 32'h0F00_0000);
    issue(mk(1, 0, 0, 0, 0, 0, 8'h08, 0, 0));
    tot = w;
    repeat (5) begin
      issue(mk(0, 0, 0, 0, 0, 0, 0, 0, 0));
      tot += w;
    end
    idle(20);
    chk(32'(tot), 32'h0000_000D);
    bus(1'h0, ACC_OFS, 32'h0); chk(rd, 32'h7800_0000);
    bus(1'h0, ara(1), 32'h0); chk(rd, 32'h0000_0003);
    bus(1'h0, STAT_OFS, 32'h0); chk(rd & 32'hF, 32'h0000_0009);
    // external fetch waits
    for (int p = 0; p < 9; p += 4) begin
      idle(6);
      issue(mk(0, 0, 0, 0, 0, 0, 0, 1, 4'(p)));
      chk(32'(w), 32'(p + 1));
    end
    idle(12);
    chk(32'(n_ret), 32'(n_ins));
    complete_run;
  end

endmodule : tb_normalize_instr_pipe_ctrl
